// ===== csrb_consts.svh
// Purpose: constants for the subtract, round, square root and branch executor
// Assumes: 24-bit words, octal opcodes, one-hot register selects
// Notes: all bus offsets and register select codes live here; opcodes live in the package
`ifndef CSRB_CONSTS_SVH
`define CSRB_CONSTS_SVH

`define CSRB_SEL_I 6'h01
`define CSRB_SEL_J 6'h02
`define CSRB_SEL_K 6'h04
`define CSRB_SEL_E 6'h08
`define CSRB_SEL_A 6'h10
`define CSRB_SEL_T 6'h20
`define CSRB_ROUND_BIT 22
`define CSRB_SIGN_BIT 23
`define CSRB_SECTION_LAST 15'h7fff
`define CSRB_BYTE_WRAP_IDX 24'h400000
`define CSRB_BYTE_ONE 2'h1
`define CSRB_SRT_STEPS 5'h0c
`define CSRB_SRE_STEPS 5'h17
`define CSRB_ADDR_OPA 12'h000
`define CSRB_ADDR_OPB 12'h004
`define CSRB_ADDR_CMD 12'h008
`define CSRB_ADDR_STAT 12'h00c
`define CSRB_ADDR_I 12'h010
`define CSRB_ADDR_J 12'h014
`define CSRB_ADDR_K 12'h018
`define CSRB_ADDR_E 12'h01c
`define CSRB_ADDR_A 12'h020
`define CSRB_ADDR_T 12'h024
`define CSRB_ADDR_P 12'h028
`define CSRB_ADDR_C 12'h02c
`define CSRB_RESP_OKAY 2'h0
`define CSRB_RESP_SLVERR 2'h2

`endif

// ===== csrb_pkg.sv
// Purpose: types for the subtract, round, square root and branch executor
// Assumes: constants come from csrb_consts.svh
// Notes: none
package csrb_pkg;
  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_ROUND     = 5'h01,
    OP_SUB_RR    = 5'h02,
    OP_SUB_MEM   = 5'h03,
    OP_SUB_DBL   = 5'h04,
    OP_SUB_BYTE  = 5'h05,
    OP_SUB_IMM   = 5'h06,
    OP_SUB_IMMB  = 5'h07,
    OP_SQRT_N    = 5'h08,
    OP_SQRT_X    = 5'h09,
    OP_JUMP_S    = 5'h0a,
    OP_JUMP_L    = 5'h0b,
    OP_JUMP_LJ   = 5'h0c,
    OP_BR_COND   = 5'h0d,
    OP_INC_BR    = 5'h0e,
    OP_BYTE_BR   = 5'h0f,
    OP_LINK      = 5'h10,
    OP_LINK_U    = 5'h11
  } csrb_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SQRT = 2'h1,
    ST_DONE = 2'h2
  } csrb_state_t;

  typedef struct packed {
    logic ovf;
    logic neg;
    logic zero;
    logic pos;
  } csrb_cond_t;

  typedef struct packed {
    csrb_op_t    op;
    logic [5:0]  src;
    logic [5:0]  dst;
    logic [2:0]  cond;
    logic [14:0] imm;
    logic        virt;
  } csrb_cmd_t;
endpackage

// ===== csrb_sqrt.sv
// Purpose: bit-serial integer square root, one root bit per clock
// Assumes: radicand up to 46 bits, start is a one-cycle pulse
// Notes: root squared plus remainder equals the top 2*steps_in bits of the radicand
`timescale 1ns/100ps
`default_nettype none
module csrb_sqrt #(
  parameter int RW = 46
) (
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic          start_in,
  input  wire logic [RW-1:0] rad_in,
  input  wire logic [4:0]    steps_in,
  output logic               done_out,
  output logic [23:0]        root_out,
  output logic [24:0]        rem_out
);
  logic [RW-1:0] rad_r;
  logic [23:0]   root_r;
  logic [24:0]   rem_r;
  logic [4:0]    cnt_r;
  logic          busy_r;
  logic [26:0]   trial;
  logic [26:0]   cand;
  logic [26:0]   diff;

  assign cand  = {rem_r, rad_r[RW-1 -: 2]};
  assign trial = {1'b0, root_r, 2'b01};
  assign diff  = cand - trial;

  // one restoring step per clock
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rad_r    <= '0;
      root_r   <= '0;
      rem_r    <= '0;
      cnt_r    <= '0;
      busy_r   <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rad_r  <= rad_in;
        root_r <= '0;
        rem_r  <= '0;
        cnt_r  <= steps_in;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rad_r <= {rad_r[RW-3:0], 2'b00};
        if (cand >= trial) begin
          rem_r  <= diff[24:0];
          root_r <= {root_r[22:0], 1'b1};
        end else begin
          rem_r  <= cand[24:0];
          root_r <= {root_r[22:0], 1'b0};
        end
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          busy_r   <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
  assign root_out = root_r;
  assign rem_out  = rem_r;
endmodule
`default_nettype wire

// ===== csrb_exec.sv
// Purpose: executes round, subtract, square root and branch instructions
// Assumes: commands and operands arrive over AXI4-Lite
// Notes: register file I J K E A T, program counter and condition held here
// How it works
// RULE_01 - round adds one when A22 set
// RULE_02 - round source kept unless it is destination
// RULE_03 - register subtract: destination minus source
// RULE_04 - memory subtract from I, J, K signed
// RULE_05 - memory subtract from E or A signed
// RULE_06 - double subtract uses words at address, address+1
// RULE_07 - double operands keep low word bit 23 zero
// RULE_08 - byte subtract touches only A bits 0-7
// RULE_09 - immediate subtract zero-extends fifteen bits; command word loads only the low twelve, top three zero
// RULE_10 - byte immediate sign-extends eight bits
// RULE_11 - root in A, remainder in E
// RULE_12 - A23 set at start flags overflow
// RULE_13 - normal root has twelve bits
// RULE_14 - extended root appends twenty-two zeros
// RULE_15 - last section word jumps to opposite section
// RULE_16 - byte step adds one to bits 22-23
// RULE_17 - byte wrap sets 01, bumps low bits
// RULE_18 - short jump 15 bits, long 16 bits
// RULE_19 - condition code picks test or negation
// RULE_20 - taken loads address, else next location
// RULE_21 - increment register, branch when nonzero
// RULE_22 - link stores return, jumps 15 bits
// RULE_23 - double register is E upper, A lower
// RULE_24 - subtract and round update condition
// RULE_25 - direct reference ignores index selection
`include "csrb_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module csrb_exec #(
  parameter int AW = 12
) (
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  logic [23:0]           regs_r [6];
  logic [15:0]           pc_r;
  csrb_pkg::csrb_cond_t  cc_r;
  logic [23:0]           opa_r;
  logic [23:0]           opb_r;
  csrb_pkg::csrb_cmd_t   cmd_r;
  csrb_pkg::csrb_state_t st_r;
  logic [AW-1:0]         awa_r;
  logic                  awh_r;
  logic [31:0]           wd_r;
  logic                  wh_r;
  logic                  sq_start_r;
  logic                  sq_ovf_r;
  logic                  sq_done;
  logic [23:0]           sq_root;
  logic [24:0]           sq_rem;

  // selected register values (one-hot)
  function automatic logic [23:0] pick(input logic [5:0] sel, input logic [23:0] r [6]);
    logic [23:0] v;
    v = 24'h000000;
    for (int i = 0; i < 6; i++) begin
      if (sel[i]) v = v | r[i];
    end
    return v;
  endfunction

  wire [23:0] src_v = pick(cmd_r.src, regs_r);
  wire [23:0] dst_v = pick(cmd_r.dst, regs_r);
  wire [23:0] reg_a = regs_r[4];
  wire [23:0] reg_e = regs_r[3];

  // arithmetic paths
  wire [23:0] round_v = reg_a[`CSRB_ROUND_BIT] ? src_v + 24'h000001 : src_v; // see RULE_01
  wire [23:0] rr_v    = dst_v - src_v;                                       // see RULE_03
  wire [23:0] mem_v   = dst_v - opa_r;                                       // see RULE_04
  wire [23:0] imm_v   = dst_v - {9'h000, cmd_r.imm};                         // see RULE_09
  wire [7:0]  smb_v   = reg_a[7:0] - opa_r[7:0];                             // see RULE_08
  wire [7:0]  sob_v   = reg_a[7:0] - cmd_r.imm[7:0];                         // see RULE_10
  // double: E upper, A lower, 23 magnitude bits in low word
  wire [46:0] dbl_d   = {reg_e, reg_a[22:0]};                                // see RULE_23
  wire [46:0] dbl_m   = {opa_r, opb_r[22:0]};                                // see RULE_06
  wire [46:0] dbl_v   = dbl_d - dbl_m;
  wire        dbl_ovf = (dbl_d[46] != dbl_m[46]) && (dbl_v[46] != dbl_d[46]);

  function automatic logic sub_ovf(input logic [23:0] a, input logic [23:0] b,
                                   input logic [23:0] r);
    return (a[23] != b[23]) && (r[23] != a[23]);
  endfunction

  function automatic csrb_pkg::csrb_cond_t cond_of(input logic [23:0] v, input logic o);
    csrb_pkg::csrb_cond_t c;
    c.ovf  = o;
    c.neg  = v[23];
    c.zero = (v == 24'h000000);
    c.pos  = !v[23] && (v != 24'h000000);
    return c;
  endfunction

  // branch targets and tests
  wire [15:0] seq_pc   = pc_r + 16'h0001;
  wire        last_wd  = !cmd_r.virt && (pc_r[14:0] == `CSRB_SECTION_LAST);
  // last word of a section flips the section bit for short branches
  wire [15:0] t15      = {pc_r[15] ^ last_wd, opa_r[14:0]};                 // see RULE_15
  wire [15:0] t16      = opa_r[15:0];                                        // see RULE_18
  // long forms use the direct address: index selection ignored, J always for indexed
  wire [15:0] t16_j    = opa_r[15:0] + regs_r[1][15:0];                      // see RULE_25
  logic       cond_hit;
  always_comb begin
    case (cmd_r.cond[1:0])
      2'h0:    cond_hit = cc_r.ovf;
      2'h1:    cond_hit = cc_r.neg;
      2'h2:    cond_hit = cc_r.zero;
      default: cond_hit = cc_r.pos;
    endcase
    if (cmd_r.cond[2]) cond_hit = !cond_hit;                                 // see RULE_19
  end
  wire [23:0] inc_v    = dst_v + 24'h000001;                                 // see RULE_21
  wire [1:0]  bb_hi    = dst_v[23:22] + 2'h1;                                // see RULE_16
  wire [21:0] bb_lo    = dst_v[21:0] + 22'h000001;
  wire        bb_wrap  = (bb_hi == 2'h0);
  wire [23:0] bb_v     = bb_wrap ? ((bb_lo == 22'h0) ? `CSRB_BYTE_WRAP_IDX
                                    : {`CSRB_BYTE_ONE, bb_lo})
                                 : {bb_hi, dst_v[21:0]};                     // see RULE_17
  wire        bb_take  = !bb_wrap || (bb_lo != 22'h0);

  // A left-justified for both forms; the step count sets the root length
  wire        sq_ext   = (cmd_r.op == csrb_pkg::OP_SQRT_X);
  wire [45:0] sq_rad   = {1'b0, reg_a[22:0], 22'h000000};                   // see RULE_11 RULE_14
  wire [4:0]  sq_steps = sq_ext ? `CSRB_SRE_STEPS : `CSRB_SRT_STEPS;         // see RULE_13

  csrb_sqrt #(.RW(46)) u_sqrt (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .start_in (sq_start_r),
    .rad_in   (sq_rad),
    .steps_in (sq_steps),
    .done_out (sq_done),
    .root_out (sq_root),
    .rem_out  (sq_rem)
  );

  // bus decode
  wire        wr_go   = awh_r && wh_r && !s_axi_bvalid;
  wire [AW-1:0] wa    = awa_r;
  wire        wr_cmd  = wr_go && (wa == `CSRB_ADDR_CMD);
  wire        wr_opa  = wr_go && (wa == `CSRB_ADDR_OPA);
  wire        wr_opb  = wr_go && (wa == `CSRB_ADDR_OPB);
  wire        wr_pc   = wr_go && (wa == `CSRB_ADDR_P);
  wire        wr_cc   = wr_go && (wa == `CSRB_ADDR_C);
  wire        wr_rf   = wr_go && (wa >= `CSRB_ADDR_I) && (wa <= `CSRB_ADDR_T) && (wa[1:0] == 2'h0);
  wire [2:0]  wr_idx  = 3'((wa - `CSRB_ADDR_I) >> 2);
  wire        wr_ok   = wr_cmd || wr_opa || wr_opb || wr_pc || wr_cc || wr_rf;
  wire        exec_go = wr_cmd && (st_r == csrb_pkg::ST_IDLE);
  logic [31:0] rd_v;
  logic        rd_ok;
  wire [AW-1:0] ra = s_axi_araddr;
  always_comb begin
    rd_ok = 1'b1;
    if (ra == `CSRB_ADDR_OPA) rd_v = {8'h00, opa_r};
    else if (ra == `CSRB_ADDR_OPB) rd_v = {8'h00, opb_r};
    else if (ra == `CSRB_ADDR_CMD)
      rd_v = {cmd_r.op, cmd_r.src, cmd_r.dst, cmd_r.cond, cmd_r.imm[11:0]};
    else if (ra == `CSRB_ADDR_STAT) rd_v = {30'h0, st_r};
    else if (ra == `CSRB_ADDR_P) rd_v = {16'h0000, pc_r};
    else if (ra == `CSRB_ADDR_C) rd_v = {28'h0000000, cc_r};
    else if ((ra >= `CSRB_ADDR_I) && (ra <= `CSRB_ADDR_T) && (ra[1:0] == 2'h0))
      rd_v = {8'h00, regs_r[3'((ra - `CSRB_ADDR_I) >> 2)]};
    else begin
      rd_v  = 32'h00000000;
      rd_ok = 1'b0;
    end
  end

  // bus handshake
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awh_r <= 1'b0;
      wh_r  <= 1'b0;
      awa_r <= '0;
      wd_r  <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CSRB_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CSRB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awh_r <= 1'b1;
        awa_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_r <= 1'b1;
        wd_r <= s_axi_wdata;
      end
      if (wr_go) begin
        awh_r        <= 1'b0;
        wh_r         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CSRB_RESP_OKAY : `CSRB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_v;
        s_axi_rresp  <= rd_ok ? `CSRB_RESP_OKAY : `CSRB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awh_r && !s_axi_bvalid;
  assign s_axi_wready  = !wh_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // execution
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 6; i++) regs_r[i] <= 24'h000000;
      pc_r       <= 16'h0000;
      cc_r       <= '0;
      opa_r      <= 24'h000000;
      opb_r      <= 24'h000000;
      cmd_r      <= '0;
      st_r       <= csrb_pkg::ST_IDLE;
      sq_start_r <= 1'b0;
      sq_ovf_r   <= 1'b0;
    end else begin
      sq_start_r <= 1'b0;
      if (wr_opa) opa_r <= wd_r[23:0];
      if (wr_opb) opb_r <= wd_r[23:0];
      if (wr_pc) pc_r <= wd_r[15:0];
      if (wr_cc) cc_r <= wd_r[3:0];
      if (wr_rf && (wr_idx < 3'h6)) regs_r[wr_idx] <= wd_r[23:0];
      if (exec_go) begin
        cmd_r.op   <= csrb_pkg::csrb_op_t'(wd_r[31:27]);
        cmd_r.src  <= wd_r[26:21];
        cmd_r.dst  <= wd_r[20:15];
        cmd_r.cond <= wd_r[14:12];
        cmd_r.imm  <= {3'h0, wd_r[11:0]};
        cmd_r.virt <= 1'b0;
        st_r  <= csrb_pkg::ST_DONE;
        if ((csrb_pkg::csrb_op_t'(wd_r[31:27]) == csrb_pkg::OP_SQRT_N) ||
            (csrb_pkg::csrb_op_t'(wd_r[31:27]) == csrb_pkg::OP_SQRT_X)) begin
          st_r       <= csrb_pkg::ST_SQRT;
          sq_start_r <= 1'b1;
        end
      end
      case (st_r)
        csrb_pkg::ST_SQRT: begin
          if (sq_start_r) sq_ovf_r <= reg_a[`CSRB_SIGN_BIT];                // see RULE_12
          if (sq_done) begin
            regs_r[4] <= sq_root;                                            // see RULE_11
            regs_r[3] <= sq_rem[23:0];
            cc_r      <= cond_of(sq_root, sq_ovf_r);
            pc_r      <= seq_pc;
            st_r      <= csrb_pkg::ST_IDLE;
          end
        end
        csrb_pkg::ST_DONE: begin
          st_r <= csrb_pkg::ST_IDLE;
          pc_r <= seq_pc;
          for (int i = 0; i < 6; i++) begin
            if (cmd_r.dst[i]) begin
              case (cmd_r.op)
                csrb_pkg::OP_ROUND:   regs_r[i] <= round_v;                  // see RULE_02
                csrb_pkg::OP_SUB_RR:  regs_r[i] <= rr_v;
                csrb_pkg::OP_SUB_MEM: regs_r[i] <= mem_v;                    // see RULE_05
                csrb_pkg::OP_SUB_IMM: regs_r[i] <= imm_v;
                csrb_pkg::OP_INC_BR:  regs_r[i] <= inc_v;
                csrb_pkg::OP_BYTE_BR: regs_r[i] <= bb_v;
                csrb_pkg::OP_LINK:    regs_r[i] <= {8'h00, seq_pc};          // see RULE_22
                default: ;
              endcase
            end
          end
          case (cmd_r.op)
            csrb_pkg::OP_ROUND:   cc_r <= cond_of(round_v, 1'b0);            // see RULE_24
            csrb_pkg::OP_SUB_RR:  cc_r <= cond_of(rr_v, sub_ovf(dst_v, src_v, rr_v));
            csrb_pkg::OP_SUB_MEM: cc_r <= cond_of(mem_v, sub_ovf(dst_v, opa_r, mem_v));
            csrb_pkg::OP_SUB_IMM: cc_r <= cond_of(imm_v, sub_ovf(dst_v, {9'h0, cmd_r.imm}, imm_v));
            csrb_pkg::OP_SUB_DBL: begin
              regs_r[3] <= dbl_v[46:23];
              regs_r[4] <= {1'b0, dbl_v[22:0]};
              cc_r      <= cond_of(dbl_v[46:23] | {23'h0, |dbl_v[22:0]}, dbl_ovf);
            end
            csrb_pkg::OP_SUB_BYTE: begin
              regs_r[4] <= {reg_a[23:8], smb_v};
              cc_r <= cond_of({{16{smb_v[7]}}, smb_v},
                              (reg_a[7] != opa_r[7]) && (smb_v[7] != reg_a[7]));
            end
            csrb_pkg::OP_SUB_IMMB: begin
              regs_r[4] <= {reg_a[23:8], sob_v};
              cc_r <= cond_of({{16{sob_v[7]}}, sob_v},
                              (reg_a[7] != cmd_r.imm[7]) && (sob_v[7] != reg_a[7]));
            end
            csrb_pkg::OP_JUMP_S:  pc_r <= t15;
            csrb_pkg::OP_JUMP_L:  pc_r <= t16;
            csrb_pkg::OP_JUMP_LJ: pc_r <= t16_j;
            csrb_pkg::OP_BR_COND: if (cond_hit) pc_r <= t16;                 // see RULE_20
            csrb_pkg::OP_INC_BR:  if (inc_v != 24'h0) pc_r <= t16;
            csrb_pkg::OP_BYTE_BR: if (bb_take) pc_r <= t15;
            csrb_pkg::OP_LINK:    pc_r <= t15;
            csrb_pkg::OP_LINK_U:  begin
              regs_r[1] <= {8'h00, seq_pc};
              pc_r      <= t16;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_ROUND_UP: assert property ( // see RULE_01
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_ROUND && cmd_r.dst == `CSRB_SEL_J)
    |=> regs_r[1] == $past(round_v)) else $error("round result wrong");
  AST_COND_BR: assert property ( // see RULE_20
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_BR_COND)
    |=> pc_r == ($past(cond_hit) ? $past(t16) : $past(seq_pc)))
    else $error("conditional branch target wrong");
  AST_SQ_OVF: assert property ( // see RULE_12
    (st_r == csrb_pkg::ST_SQRT && sq_done) |=> cc_r.ovf == $past(sq_ovf_r))
    else $error("square root overflow flag wrong");
  AST_SQ_TIME: assert property ( // see RULE_13
    (sq_start_r && !sq_ext) |-> ##13 sq_done) else $error("normal root step count wrong");
  AST_BYTE_KEEP: assert property ( // see RULE_08
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_SUB_BYTE)
    |=> regs_r[4][23:8] == $past(reg_a[23:8])) else $error("byte subtract upper bits altered");
  AST_INC_STORE: assert property ( // see RULE_21
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_INC_BR && cmd_r.dst == `CSRB_SEL_I)
    |=> regs_r[0] == $past(regs_r[0]) + 24'h000001) else $error("increment not stored");
  AST_LINK_RET: assert property ( // see RULE_22
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_LINK && cmd_r.dst == `CSRB_SEL_K)
    |=> regs_r[2][15:0] == $past(pc_r) + 16'h0001) else $error("link return address wrong");
  AST_SUB_RR: assert property ( // see RULE_03
    (st_r == csrb_pkg::ST_DONE && cmd_r.op == csrb_pkg::OP_SUB_RR && cmd_r.dst == `CSRB_SEL_J)
    |=> regs_r[1] == $past(dst_v) - $past(src_v)) else $error("register subtract wrong");
endmodule
`default_nettype wire

// ===== csrb_decode_model.sv
// Purpose: decode stage model, masters the register bus
// Assumes: one write and one read at a time
// Notes: tmo_out flags a wait that ran out
`timescale 1ns/100ps
`default_nettype none
module csrb_decode_model (
  input  wire logic        clock_in,
  output logic [11:0]      awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  output logic [11:0]      araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out,
  output logic             tmo_out
);
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out, tmo_out} = '0;
    {awaddr_out, wdata_out, araddr_out} = '0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
    end while (bvalid_in !== 1'b1 && n < 200);
    r = bresp_in;
    bready_out <= 1'b0;
    if (bvalid_in !== 1'b1) tmo_out = 1'b1;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (arready_in) arvalid_out <= 1'b0;
    end while (rvalid_in !== 1'b1 && n < 200);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
    if (rvalid_in !== 1'b1) tmo_out = 1'b1;
    @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench
// Assumes: command word op, src, dst, cond, imm
// Notes: expectations by hand
`timescale 1ns/100ps
`default_nettype none
`include "csrb_consts.svh"
module testbench;
  logic clock_in, rst_n_in, tmo;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int errors, compares;
  csrb_exec csrb_exec_inst (.clock_in, .rst_n_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  csrb_decode_model csrb_decode_model_inst (.clock_in, .awaddr_out(s_axi_awaddr),
    .awvalid_out(s_axi_awvalid), .awready_in(s_axi_awready), .wdata_out(s_axi_wdata),
    .wvalid_out(s_axi_wvalid), .wready_in(s_axi_wready), .bresp_in(s_axi_bresp),
    .bvalid_in(s_axi_bvalid), .bready_out(s_axi_bready), .araddr_out(s_axi_araddr),
    .arvalid_out(s_axi_arvalid), .arready_in(s_axi_arready), .rdata_in(s_axi_rdata),
    .rresp_in(s_axi_rresp), .rvalid_in(s_axi_rvalid), .rready_out(s_axi_rready),
    .tmo_out(tmo));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic tally_and_finish();
    if (tmo !== 1'b0) errors++;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] r;
    csrb_decode_model_inst.wr(a, v, r);
    if (tmo !== 1'b0) tally_and_finish();
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    csrb_decode_model_inst.rd(a, d, r);
    if (tmo !== 1'b0) tally_and_finish();
    chk(d, e);
  endtask
  task automatic run(input logic [4:0] op, input logic [5:0] s, input logic [5:0] d,
                     input logic [2:0] c, input logic [23:0] opa, input logic [23:0] opb);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    wr(`CSRB_ADDR_OPA, opa);
    wr(`CSRB_ADDR_OPB, opb);
    wr(`CSRB_ADDR_CMD, {op, s, d, c, opa[11:0]});
    n = 0;
    st = 32'h1;
    while (st !== 32'h0 && n < 100) begin
      csrb_decode_model_inst.rd(`CSRB_ADDR_STAT, st, r);
      n++;
    end
    if (st !== 32'h0 || tmo !== 1'b0) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic br(input logic [4:0] op, input logic [5:0] s, input logic [2:0] c,
                    input logic [31:0] p);
    wr(`CSRB_ADDR_P, 24'h100);
    run(op, s, s, c, 24'h9234, 24'h0);
    rdc(`CSRB_ADDR_P, p);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdc(`CSRB_ADDR_STAT, 32'h0);
    csrb_decode_model_inst.rd(12'h030, d, r);
    chk({30'h0, r}, {30'h0, `CSRB_RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_round();
    wr(`CSRB_ADDR_A, 24'h400000);
    wr(`CSRB_ADDR_I, 24'h5);
    run(csrb_pkg::OP_ROUND, `CSRB_SEL_I, `CSRB_SEL_J, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_J, 32'h6);
    rdc(`CSRB_ADDR_I, 32'h5);
    run(csrb_pkg::OP_ROUND, `CSRB_SEL_I, `CSRB_SEL_I, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_I, 32'h6);
    wr(`CSRB_ADDR_A, 24'h0);
    run(csrb_pkg::OP_ROUND, `CSRB_SEL_I, `CSRB_SEL_K, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_K, 32'h6);
    $display("test round done");
  endtask
  task automatic t_sub();
    wr(`CSRB_ADDR_J, 24'ha);
    wr(`CSRB_ADDR_I, 24'h3);
    run(csrb_pkg::OP_SUB_RR, `CSRB_SEL_I, `CSRB_SEL_J, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_J, 32'h7);
    rdc(`CSRB_ADDR_C, 32'h1);
    wr(`CSRB_ADDR_K, 24'h2);
    run(csrb_pkg::OP_SUB_MEM, 6'h0, `CSRB_SEL_K, 3'h0, 24'h5, 24'h0);
    rdc(`CSRB_ADDR_K, 32'hfffffd);
    rdc(`CSRB_ADDR_C, 32'h4);
    wr(`CSRB_ADDR_E, 24'h0);
    run(csrb_pkg::OP_SUB_MEM, 6'h0, `CSRB_SEL_E, 3'h0, 24'h1, 24'h0);
    rdc(`CSRB_ADDR_E, 32'hffffff);
    wr(`CSRB_ADDR_A, 24'h123400);
    run(csrb_pkg::OP_SUB_BYTE, 6'h0, `CSRB_SEL_A, 3'h0, 24'h1, 24'h0);
    rdc(`CSRB_ADDR_A, 32'h1234ff);
    run(csrb_pkg::OP_SUB_IMMB, 6'h0, `CSRB_SEL_A, 3'h0, 24'hfe, 24'h0);
    rdc(`CSRB_ADDR_A, 32'h123401);
    wr(`CSRB_ADDR_T, 24'h10);
    run(csrb_pkg::OP_SUB_IMM, 6'h0, `CSRB_SEL_T, 3'h0, 24'h20, 24'h0);
    rdc(`CSRB_ADDR_T, 32'hfffff0);
    wr(`CSRB_ADDR_E, 24'h1);
    wr(`CSRB_ADDR_A, 24'h0);
    run(csrb_pkg::OP_SUB_DBL, 6'h0, 6'h0, 3'h0, 24'h0, 24'h1);
    rdc(`CSRB_ADDR_E, 32'h0);
    rdc(`CSRB_ADDR_A, 32'h7fffff);
    $display("test subtract done");
  endtask
  task automatic t_sqrt();
    wr(`CSRB_ADDR_A, 24'h65);
    run(csrb_pkg::OP_SQRT_N, 6'h0, 6'h0, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_A, 32'ha);
    rdc(`CSRB_ADDR_E, 32'h1);
    wr(`CSRB_ADDR_A, 24'h4);
    run(csrb_pkg::OP_SQRT_X, 6'h0, 6'h0, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_A, 32'h1000);
    wr(`CSRB_ADDR_A, 24'h800000);
    run(csrb_pkg::OP_SQRT_N, 6'h0, 6'h0, 3'h0, 24'h0, 24'h0);
    rdc(`CSRB_ADDR_C, 32'ha);
    $display("test root done");
  endtask
  task automatic t_branch();
    wr(`CSRB_ADDR_T, 24'h5);
    run(csrb_pkg::OP_SUB_IMM, 6'h0, `CSRB_SEL_T, 3'h0, 24'h1, 24'h0);
    for (int c = 0; c < 8; c++) begin
      br(csrb_pkg::OP_BR_COND, 6'h0, c[2:0], (c > 2 && c < 7) ? 32'h9234 : 32'h101);
    end
    br(csrb_pkg::OP_JUMP_S, 6'h0, 3'h0, 32'h1234);
    br(csrb_pkg::OP_JUMP_L, 6'h0, 3'h0, 32'h9234);
    wr(`CSRB_ADDR_I, 24'hffffff);
    br(csrb_pkg::OP_INC_BR, `CSRB_SEL_I, 3'h0, 32'h101);
    rdc(`CSRB_ADDR_I, 32'h0);
    br(csrb_pkg::OP_INC_BR, `CSRB_SEL_I, 3'h0, 32'h9234);
    wr(`CSRB_ADDR_J, 24'h5);
    br(csrb_pkg::OP_BYTE_BR, `CSRB_SEL_J, 3'h0, 32'h1234);
    rdc(`CSRB_ADDR_J, 32'h400005);
    wr(`CSRB_ADDR_J, 24'hffffff);
    br(csrb_pkg::OP_BYTE_BR, `CSRB_SEL_J, 3'h0, 32'h101);
    rdc(`CSRB_ADDR_J, 32'h400000);
    br(csrb_pkg::OP_LINK, `CSRB_SEL_K, 3'h0, 32'h1234);
    rdc(`CSRB_ADDR_K, 32'h101);
    wr(`CSRB_ADDR_J, 24'h10);
    br(csrb_pkg::OP_JUMP_LJ, 6'h0, 3'h0, 32'h9244);
    br(csrb_pkg::OP_LINK_U, 6'h0, 3'h0, 32'h9234);
    rdc(`CSRB_ADDR_J, 32'h101);
    $display("test branch done");
  endtask
  initial begin
    errors = 0;
    compares = 0;
    rst_n_in = 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_round();
    t_sub();
    t_sqrt();
    t_branch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
